// file: verilog/tpsc_defines.svh
// constants of the tuner synthesizer serial control block
`ifndef TPSC_DEFINES_SVH
`define TPSC_DEFINES_SVH
`define TPSC_ADDR_FIXED   5'h18
`define TPSC_BIT_LAST     3'h7
`define TPSC_CNT_FULL     4'h8
`define TPSC_TEST_AUX     3'h3
`define TPSC_TEST_PUMPOFF 3'h2
`define TPSC_TEST_SINK    3'h6
`define TPSC_TEST_SOURCE  3'h7
`define TPSC_TEST_HALFREF 3'h4
`define TPSC_TEST_HALFDIV 3'h5
`define TPSC_RST_FREQ     15'h0000
`define TPSC_RST_CTRL     8'hC9
`define TPSC_RST_BAND     8'h00
`define TPSC_RST_AUX      8'h20
`define TPSC_RST_MISC     21'h001C80
`define TPSC_RATIO_80     8'h50
`define TPSC_RATIO_128    8'h80
`define TPSC_RATIO_64     8'h40
`define TPSC_TOP_115      7'h73
`define TPSC_TOP_112      7'h70
`define TPSC_TOP_109      7'h6D
`define TPSC_TOP_106      7'h6A
`define TPSC_TOP_103      7'h67
`define TPSC_TOP_NONE     7'h00
`define TPSC_STAT_ONES    2'h3
`endif

// file: verilog/tpsc_pkg.sv
// types of the tuner synthesizer serial control block
package tpsc_pkg;
    typedef enum logic [2:0] {
        TPSC_IDLE = 3'b000,
        TPSC_ADDR = 3'b001,
        TPSC_AACK = 3'b010,
        TPSC_RX   = 3'b011,
        TPSC_RACK = 3'b100,
        TPSC_TX   = 3'b101,
        TPSC_TACK = 3'b110,
        TPSC_SKIP = 3'b111
    } tpsc_state_t;
    typedef enum logic [1:0] {
        TPSC_K_FIRST = 2'b00,
        TPSC_K_DB2   = 2'b01,
        TPSC_K_BB    = 2'b10,
        TPSC_K_AB    = 2'b11
    } tpsc_kind_t;
endpackage : tpsc_pkg

// file: verilog/tpsc_serial_ctrl.sv
// serial bus slave and setting registers of the tuner synthesizer
`timescale 1ns/1ps
`include "tpsc_defines.svh"
module tpsc_serial_ctrl (
    input  wire logic       clk,
    input  wire logic       rst_b,
    input  wire logic       sclIn,
    input  wire logic       sdaIn,
    input  wire logic [1:0] addressSelectInput,
    input  wire logic       lockFlagIn,
    input  wire logic       agcActiveIn,
    input  wire logic [2:0] converterCodeIn,
    input  wire logic       refTick,
    input  wire logic       divTick,
    output logic            sdaOe,
    output logic            lowBandPortOe,
    output logic            midBandPortOe,
    output logic            sourcePortAOe,
    output logic            sourcePortBOe,
    output logic            sinkPortAOe,
    output logic            sharedPinOe,
    output logic            lowMixerEn,
    output logic            midHighMixerEn,
    output logic            lowOscEn,
    output logic            midOscEn,
    output logic            highOscEn,
    output logic [14:0]     dividerRatioBits,
    output logic            pumpCurrentSelect,
    output logic [2:0]      testField,
    output logic [7:0]      refDivRatio,
    output logic            tuningOutputOff,
    output logic            pumpOff,
    output logic            pumpSink,
    output logic            pumpSource,
    output logic            agcTimeConstant,
    output logic [6:0]      takeoverDbuv,
    output logic            agcExternal,
    output logic            agcDisabled
);
    import tpsc_pkg::*;

    ////////////////////////////////////////////////////////////////////
    // pin synchronisers: a level changes once stages two and three agree
    localparam int NPIN = 9;
    logic [NPIN-1:0] pinRaw;
    logic [NPIN-1:0] syn1_reg;
    logic [NPIN-1:0] syn2_reg;
    logic [NPIN-1:0] syn3_reg;
    logic [NPIN-1:0] lvl_reg;
    logic [NPIN-1:0] lvl_next;

    assign pinRaw = {addressSelectInput, converterCodeIn, agcActiveIn,
                     lockFlagIn, sdaIn, sclIn};

    genvar gi;
    generate
        for (gi = 0; gi < NPIN; gi++) begin : g_sync
            always_comb begin
                lvl_next[gi] = lvl_reg[gi];
                if (syn2_reg[gi] == syn3_reg[gi]) begin
                    lvl_next[gi] = syn3_reg[gi];
                end
            end
            always_ff @(posedge clk or negedge rst_b) begin
                if (!rst_b) begin
                    syn1_reg[gi] <= 1'b1;
                    syn2_reg[gi] <= 1'b1;
                    syn3_reg[gi] <= 1'b1;
                    lvl_reg[gi]  <= 1'b1;
                end else begin
                    syn1_reg[gi] <= pinRaw[gi];
                    syn2_reg[gi] <= syn1_reg[gi];
                    syn3_reg[gi] <= syn2_reg[gi];
                    lvl_reg[gi]  <= lvl_next[gi];
                end
            end
        end
    endgenerate

    logic       scl;
    logic       sda;
    logic [1:0] maBits;
    logic [7:0] statusByte;
    assign scl    = lvl_reg[0];
    assign sda    = lvl_reg[1];
    assign maBits = lvl_reg[8:7];

    ////////////////////////////////////////////////////////////////////
    // bus state
    tpsc_state_t st_reg,  st_next;
    tpsc_kind_t  kind_reg, kind_next;
    logic [3:0]  cnt_reg,   cnt_next;
    logic [7:0]  sh_reg,    sh_next;
    logic        rw_reg,    rw_next;
    logic        sdaOe_reg, sdaOe_next;
    logic        sclP_reg,  sclP_next;
    logic        sdaP_reg,  sdaP_next;
    logic        por_reg,   por_next;
    logic [6:0]  db1_reg,   db1_next;
    logic [14:0] freq_reg,  freq_next;
    logic [7:0]  ctrl_reg,  ctrl_next;
    logic [7:0]  band_reg,  band_next;
    logic [7:0]  aux_reg,   aux_next;

    logic       sclRise;
    logic       sclFall;
    logic       startCond;
    logic       stopCond;
    logic [7:0] newByte;

    // status: power-on flag, lock, two ones, AGC, converter code
    assign statusByte = {por_reg, lvl_reg[2], `TPSC_STAT_ONES,
                         lvl_reg[3], lvl_reg[6:4]};

    always_comb begin
        sclRise   = scl & ~sclP_reg;
        sclFall   = ~scl & sclP_reg;
        startCond = scl & sclP_reg & sdaP_reg & ~sda;
        stopCond  = scl & sclP_reg & ~sdaP_reg & sda;
        newByte   = {sh_reg[6:0], sda};
        st_next    = st_reg;
        kind_next  = kind_reg;
        cnt_next   = cnt_reg;
        sh_next    = sh_reg;
        rw_next    = rw_reg;
        sdaOe_next = sdaOe_reg;
        sclP_next  = scl;
        sdaP_next  = sda;
        por_next   = por_reg;
        db1_next   = db1_reg;
        freq_next  = freq_reg;
        ctrl_next  = ctrl_reg;
        band_next  = band_reg;
        aux_next   = aux_reg;
        if (stopCond) begin
            st_next    = TPSC_IDLE;
            sdaOe_next = 1'b0;
        end else if (startCond) begin
            // a repeated start also restarts the byte sequence
            st_next    = TPSC_ADDR;
            cnt_next   = 4'h0;
            kind_next  = TPSC_K_FIRST;
            sdaOe_next = 1'b0;
        end else begin
            case (st_reg)
                TPSC_ADDR: begin
                    if (sclRise) begin
                        sh_next  = newByte;
                        cnt_next = cnt_reg + 4'h1;
                    end else if (sclFall && cnt_reg == `TPSC_CNT_FULL) begin
                        cnt_next = 4'h0;
                        if (sh_reg[7:1] == {`TPSC_ADDR_FIXED, maBits}) begin
                            st_next    = TPSC_AACK;
                            sdaOe_next = 1'b1;
                            rw_next    = sh_reg[0];
                        end else begin
                            st_next = TPSC_SKIP;
                        end
                    end
                end
                TPSC_AACK: begin
                    if (sclFall) begin
                        cnt_next = 4'h0;
                        if (rw_reg) begin
                            st_next    = TPSC_TX;
                            sh_next    = statusByte;
                            sdaOe_next = ~statusByte[7];
                        end else begin
                            st_next    = TPSC_RX;
                            sdaOe_next = 1'b0;
                        end
                    end
                end
                TPSC_RX: begin
                    if (sclRise) begin
                        sh_next  = newByte;
                        cnt_next = cnt_reg + 4'h1;
                        if (cnt_reg[2:0] == `TPSC_BIT_LAST) begin
                            // eighth clock of the byte: load at once
                            case (kind_reg)
                                TPSC_K_FIRST: begin
                                    if (!newByte[7]) begin
                                        db1_next  = newByte[6:0];
                                        kind_next = TPSC_K_DB2;
                                    end else begin
                                        ctrl_next = newByte;
                                        if (newByte[5:3] == `TPSC_TEST_AUX) begin
                                            kind_next = TPSC_K_AB;
                                        end else begin
                                            kind_next = TPSC_K_BB;
                                        end
                                    end
                                end
                                TPSC_K_DB2: begin
                                    freq_next = {db1_reg, newByte};
                                    kind_next = TPSC_K_FIRST;
                                end
                                TPSC_K_BB: begin
                                    band_next = newByte;
                                    kind_next = TPSC_K_FIRST;
                                end
                                default: begin
                                    // low four bits are kept as zero
                                    aux_next  = {newByte[7:4], 4'h0};
                                    kind_next = TPSC_K_FIRST;
                                end
                            endcase
                        end
                    end else if (sclFall && cnt_reg == `TPSC_CNT_FULL) begin
                        st_next    = TPSC_RACK;
                        sdaOe_next = 1'b1;
                    end
                end
                TPSC_RACK: begin
                    if (sclFall) begin
                        st_next    = TPSC_RX;
                        cnt_next   = 4'h0;
                        sdaOe_next = 1'b0;
                    end
                end
                TPSC_TX: begin
                    if (sclFall) begin
                        if (cnt_reg[2:0] == `TPSC_BIT_LAST) begin
                            st_next    = TPSC_TACK;
                            cnt_next   = 4'h0;
                            sdaOe_next = 1'b0;
                        end else begin
                            cnt_next   = cnt_reg + 4'h1;
                            sh_next    = {sh_reg[6:0], 1'b0};
                            sdaOe_next = ~sh_reg[6];
                        end
                    end
                end
                TPSC_TACK: begin
                    if (sclRise) begin
                        if (sda) begin
                            // no master acknowledge ends the read
                            st_next  = TPSC_SKIP;
                            por_next = 1'b0;
                        end else begin
                            cnt_next = 4'h1;
                        end
                    end else if (sclFall && cnt_reg == 4'h1) begin
                        st_next    = TPSC_TX;
                        cnt_next   = 4'h0;
                        sh_next    = statusByte;
                        sdaOe_next = ~statusByte[7];
                    end
                end
                default: begin
                    sdaOe_next = 1'b0;
                end
            endcase
        end
    end

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            st_reg    <= TPSC_IDLE;
            kind_reg  <= TPSC_K_FIRST;
            cnt_reg   <= 4'h0;
            sh_reg    <= 8'h00;
            rw_reg    <= 1'b0;
            sdaOe_reg <= 1'b0;
            sclP_reg  <= 1'b1;
            sdaP_reg  <= 1'b1;
            por_reg   <= 1'b1;
            db1_reg   <= 7'h00;
            freq_reg  <= `TPSC_RST_FREQ;
            ctrl_reg  <= `TPSC_RST_CTRL;
            band_reg  <= `TPSC_RST_BAND;
            aux_reg   <= `TPSC_RST_AUX;
        end else begin
            st_reg    <= st_next;
            kind_reg  <= kind_next;
            cnt_reg   <= cnt_next;
            sh_reg    <= sh_next;
            rw_reg    <= rw_next;
            sdaOe_reg <= sdaOe_next;
            sclP_reg  <= sclP_next;
            sdaP_reg  <= sdaP_next;
            por_reg   <= por_next;
            db1_reg   <= db1_next;
            freq_reg  <= freq_next;
            ctrl_reg  <= ctrl_next;
            band_reg  <= band_next;
            aux_reg   <= aux_next;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // decoded settings, registered so every output leaves a flop
    logic [2:0] tf;
    logic [7:0] ratio_reg, ratio_next;
    logic [6:0] top_reg,   top_next;
    logic [20:0] misc_reg, misc_next;
    logic       half_reg,  half_next;

    assign tf = ctrl_reg[5:3];

    always_comb begin
        ratio_next = ratio_reg;
        case (ctrl_reg[2:1])
            2'b00:   ratio_next = `TPSC_RATIO_80;
            2'b01:   ratio_next = `TPSC_RATIO_128;
            2'b11:   ratio_next = `TPSC_RATIO_64;
            // forbidden code keeps the last legal ratio
            default: ratio_next = ratio_reg;
        endcase
        case (aux_reg[6:4])
            3'b010:  top_next = `TPSC_TOP_112;
            3'b011:  top_next = `TPSC_TOP_109;
            3'b100:  top_next = `TPSC_TOP_106;
            3'b101:  top_next = `TPSC_TOP_103;
            3'b110:  top_next = `TPSC_TOP_NONE;
            3'b111:  top_next = `TPSC_TOP_NONE;
            default: top_next = `TPSC_TOP_115;
        endcase
        // half-rate test outputs toggle on each input tick
        half_next = half_reg;
        if ((tf == `TPSC_TEST_HALFREF && refTick) ||
            (tf == `TPSC_TEST_HALFDIV && divTick)) begin
            half_next = ~half_reg;
        end
        misc_next[0]  = band_reg[0];
        misc_next[1]  = band_reg[1];
        misc_next[2]  = band_reg[2];
        misc_next[3]  = band_reg[3];
        misc_next[4]  = band_reg[4];
        // test output pulls the shared pin low in its low phase
        if (tf == `TPSC_TEST_HALFREF || tf == `TPSC_TEST_HALFDIV) begin
            misc_next[5] = ~half_next;
        end else begin
            misc_next[5] = band_reg[6];
        end
        misc_next[6]  = band_reg[0];
        misc_next[7]  = band_reg[1] | ~band_reg[0];
        misc_next[8]  = band_reg[0];
        misc_next[9]  = band_reg[1];
        misc_next[10] = ~band_reg[0] & ~band_reg[1];
        misc_next[11] = ctrl_reg[6];
        misc_next[12] = ctrl_reg[0];
        misc_next[13] = (tf == `TPSC_TEST_PUMPOFF);
        misc_next[14] = (tf == `TPSC_TEST_SINK);
        misc_next[15] = (tf == `TPSC_TEST_SOURCE);
        misc_next[16] = aux_reg[7];
        misc_next[17] = (aux_reg[6:4] == 3'b110);
        misc_next[18] = (aux_reg[6:4] == 3'b111);
        misc_next[20:19] = 2'b00;
    end

    always_ff @(posedge clk or negedge rst_b) begin
        if (!rst_b) begin
            ratio_reg <= `TPSC_RATIO_80;
            top_reg   <= `TPSC_TOP_112;
            // high band selected, high pump current, tuning output off
            misc_reg  <= `TPSC_RST_MISC;
            half_reg  <= 1'b0;
        end else begin
            ratio_reg <= ratio_next;
            top_reg   <= top_next;
            misc_reg  <= misc_next;
            half_reg  <= half_next;
        end
    end

    assign sdaOe             = sdaOe_reg;
    assign lowBandPortOe     = misc_reg[0];
    assign midBandPortOe     = misc_reg[1];
    assign sourcePortAOe     = misc_reg[2];
    assign sourcePortBOe     = misc_reg[3];
    assign sinkPortAOe       = misc_reg[4];
    assign sharedPinOe       = misc_reg[5];
    assign lowMixerEn        = misc_reg[6];
    assign midHighMixerEn    = misc_reg[7];
    assign lowOscEn          = misc_reg[8];
    assign midOscEn          = misc_reg[9];
    assign highOscEn         = misc_reg[10];
    assign dividerRatioBits  = freq_reg;
    assign pumpCurrentSelect = misc_reg[11];
    assign testField         = ctrl_reg[5:3];
    assign refDivRatio       = ratio_reg;
    assign tuningOutputOff   = misc_reg[12];
    assign pumpOff           = misc_reg[13];
    assign pumpSink          = misc_reg[14];
    assign pumpSource        = misc_reg[15];
    assign agcTimeConstant   = misc_reg[16];
    assign takeoverDbuv      = top_reg;
    assign agcExternal       = misc_reg[17];
    assign agcDisabled       = misc_reg[18];
endmodule : tpsc_serial_ctrl

// file: tb/tpsc_serial_ctrl_chk.sv
// concurrent checks on the serial control ports
`timescale 1ns/1ps
module tpsc_serial_ctrl_chk (
    input wire logic       clk,
    input wire logic       rst_b,
    input wire logic       sclIn,
    input wire logic       sdaIn,
    input wire logic       sdaOe,
    input wire logic       lowBandPortOe,
    input wire logic       midBandPortOe,
    input wire logic       lowMixerEn,
    input wire logic       midHighMixerEn,
    input wire logic       lowOscEn,
    input wire logic       midOscEn,
    input wire logic       highOscEn,
    input wire logic [7:0] refDivRatio,
    input wire logic [2:0] testField,
    input wire logic       pumpOff,
    input wire logic       pumpSink,
    input wire logic       pumpSource,
    input wire logic [6:0] takeoverDbuv,
    input wire logic       agcExternal,
    input wire logic       agcDisabled
);
    default clocking @(posedge clk); endclocking
    default disable iff (!rst_b);
    // decoded enables change in the same clock as the port registers
    sequence s_lowHeld;  lowBandPortOe[*4]; endsequence
    sequence s_midHeld;  midBandPortOe[*4]; endsequence
    sequence s_noneHeld; (!lowBandPortOe && !midBandPortOe)[*4]; endsequence
    sequence s_stop;     sclIn && $rose(sdaIn); endsequence
    property p_lowBand;  s_lowHeld |-> lowMixerEn && lowOscEn; endproperty
    property p_midBand;  s_midHeld |-> midHighMixerEn && midOscEn; endproperty
    property p_highBand;
        s_noneHeld |-> midHighMixerEn && highOscEn && !lowMixerEn && !midOscEn;
    endproperty
    property p_ratio;    refDivRatio inside {8'h50, 8'h80, 8'h40}; endproperty
    property p_pumpOff;
        (testField == 3'h2)[*3] |-> pumpOff && !pumpSink && !pumpSource;
    endproperty
    property p_agcOff;   (agcExternal || agcDisabled)[*3] |-> takeoverDbuv == 7'h00; endproperty
    // the device only ever starts pulling data low in a low phase of the bus clock
    property p_ackLow;   $rose(sdaOe) |-> !sclIn && !$past(sclIn) && !$past(sclIn, 2); endproperty
    property p_stopIdle; s_stop |-> (!sdaOe)[*8]; endproperty
    a_lowBand: assert property (p_lowBand) else $error("low band enables wrong");
    a_midBand: assert property (p_midBand) else $error("mid band enables wrong");
    a_highBand: assert property (p_highBand) else $error("high band enables wrong");
    a_ratio: assert property (p_ratio) else $error("reference ratio illegal");
    a_pumpOff: assert property (p_pumpOff) else $error("pump off decode wrong");
    a_agcOff: assert property (p_agcOff) else $error("take-over not cleared");
    a_ackLow: assert property (p_ackLow) else $error("data pulled in high phase");
    a_stopIdle: assert property (p_stopIdle) else $error("data pulled after stop");
endmodule : tpsc_serial_ctrl_chk
bind tpsc_serial_ctrl tpsc_serial_ctrl_chk i_chk (
    .clk(clk), .rst_b(rst_b), .sclIn(sclIn), .sdaIn(sdaIn), .sdaOe(sdaOe),
    .lowBandPortOe(lowBandPortOe), .midBandPortOe(midBandPortOe), .lowMixerEn(lowMixerEn),
    .midHighMixerEn(midHighMixerEn), .lowOscEn(lowOscEn), .midOscEn(midOscEn),
    .highOscEn(highOscEn), .refDivRatio(refDivRatio), .testField(testField),
    .pumpOff(pumpOff), .pumpSink(pumpSink), .pumpSource(pumpSource),
    .takeoverDbuv(takeoverDbuv), .agcExternal(agcExternal), .agcDisabled(agcDisabled)
);

// file: tb/tpsc_host_model.sv
// serial bus master model driving the bus clock and data pins
`timescale 1ns/1ps
module tpsc_host_model (
    input  wire logic clk,
    input  wire logic sdaOe,
    output logic      sclIn,
    output logic      sdaIn
);
    logic hostSda;
    // pull-up wire: low while either party pulls
    assign sdaIn = hostSda & ~sdaOe;
    initial begin
        sclIn   = 1'b1;
        hostSda = 1'b1;
    end
    task automatic hold(input int n);
        repeat (n) @(posedge clk);
    endtask : hold
    task automatic pin_bit(input logic b, output logic r);
        hostSda <= b;
        hold(10);
        sclIn <= 1'b1;
        hold(10);
        r = sdaIn;
        sclIn <= 1'b0;
    endtask : pin_bit
    task automatic start_cond();
        hostSda <= 1'b1;
        hold(10);
        sclIn <= 1'b1;
        hold(10);
        hostSda <= 1'b0;
        hold(10);
        sclIn <= 1'b0;
    endtask : start_cond
    task automatic stop_cond();
        hostSda <= 1'b0;
        hold(10);
        sclIn <= 1'b1;
        hold(10);
        hostSda <= 1'b1;
        hold(10);
    endtask : stop_cond
    task automatic xfer(input logic [7:0] d, input logic ninth, output logic [7:0] r,
                        output logic ack);
        logic b;
        for (int i = 7; i >= 0; i--) begin
            pin_bit(d[i], b);
            r[i] = b;
        end
        pin_bit(ninth, b);
        ack = ~b;
    endtask : xfer
endmodule : tpsc_host_model

// file: tb/tb_tpsc_serial_ctrl.sv
// self-checking bench of the tuner synthesizer serial control
`timescale 1ns/1ps
module tb_tpsc_serial_ctrl;
    localparam logic [7:0] ADRW = {5'h18, 2'b10, 1'b0};
    logic        clk, rst_b, sclIn, sdaIn, lockFlagIn, agcActiveIn, refTick, divTick;
    logic        sdaOe, lowBandPortOe, midBandPortOe, sourcePortAOe, sourcePortBOe;
    logic        sinkPortAOe, sharedPinOe, lowMixerEn, midHighMixerEn, lowOscEn, midOscEn;
    logic        highOscEn, pumpCurrentSelect, tuningOutputOff, pumpOff, pumpSink, pumpSource;
    logic        agcTimeConstant, agcExternal, agcDisabled, last;
    logic [1:0]  addressSelectInput, bnd;
    logic [2:0]  converterCodeIn, testField;
    logic [6:0]  takeoverDbuv;
    logic [7:0]  refDivRatio, rat, tick;
    logic [14:0] dividerRatioBits;
    int          err_count, checks, chg;
    logic [5:0]  ports, pump, ctl;
    logic [4:0]  band;
    logic [9:0]  agc;
    logic [1:0]  rsTab[4] = '{2'b00, 2'b01, 2'b11, 2'b10};
    logic [7:0]  ratTab[3] = '{8'h50, 8'h80, 8'h40};
    logic [6:0]  topTab[8] = '{7'h73, 7'h73, 7'h70, 7'h6D, 7'h6A, 7'h67, 7'h00, 7'h00};
    assign ports = {lowBandPortOe, midBandPortOe, sourcePortAOe, sourcePortBOe, sinkPortAOe,
                    sharedPinOe};
    assign band = {lowMixerEn, midHighMixerEn, lowOscEn, midOscEn, highOscEn};
    assign pump = {testField, pumpOff, pumpSink, pumpSource};
    assign ctl = {pumpCurrentSelect, tuningOutputOff, testField, agcTimeConstant};
    assign agc = {agcTimeConstant, agcExternal, agcDisabled, takeoverDbuv};
    tpsc_serial_ctrl i_tpsc_serial_ctrl (
        .clk(clk), .rst_b(rst_b), .sclIn(sclIn), .sdaIn(sdaIn),
        .addressSelectInput(addressSelectInput), .lockFlagIn(lockFlagIn),
        .agcActiveIn(agcActiveIn), .converterCodeIn(converterCodeIn), .refTick(refTick),
        .divTick(divTick), .sdaOe(sdaOe), .lowBandPortOe(lowBandPortOe),
        .midBandPortOe(midBandPortOe), .sourcePortAOe(sourcePortAOe),
        .sourcePortBOe(sourcePortBOe), .sinkPortAOe(sinkPortAOe), .sharedPinOe(sharedPinOe),
        .lowMixerEn(lowMixerEn), .midHighMixerEn(midHighMixerEn), .lowOscEn(lowOscEn),
        .midOscEn(midOscEn), .highOscEn(highOscEn), .dividerRatioBits(dividerRatioBits),
        .pumpCurrentSelect(pumpCurrentSelect), .testField(testField),
        .refDivRatio(refDivRatio), .tuningOutputOff(tuningOutputOff), .pumpOff(pumpOff),
        .pumpSink(pumpSink), .pumpSource(pumpSource), .agcTimeConstant(agcTimeConstant),
        .takeoverDbuv(takeoverDbuv), .agcExternal(agcExternal), .agcDisabled(agcDisabled)
    );
    tpsc_host_model i_tpsc_host_model (.clk(clk), .sdaOe(sdaOe), .sclIn(sclIn), .sdaIn(sdaIn));
    ////////////////////////////////////////////////////////////////////////////////
    task automatic chk(input string what, input logic [15:0] exp, input logic [15:0] got);
        checks++;
        if (got !== exp) begin
            err_count++;
            $display("ERROR %s expected %h seen %h", what, exp, got);
        end
    endtask : chk
    task automatic endt(input string n);
        $display("test %s done, errors %0d", n, err_count);
    endtask : endt
    task automatic finish_test();
        $display("checks %0d errors %0d", checks, err_count);
        if (err_count == 0 && checks > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask : finish_test
    task automatic wr(input logic [7:0] q[$], input logic expAck);
        logic [7:0] r;
        logic       a;
        i_tpsc_host_model.start_cond();
        foreach (q[i]) begin
            i_tpsc_host_model.xfer(q[i], 1'b1, r, a);
            chk("ack", 16'(expAck), 16'(a));
        end
        i_tpsc_host_model.stop_cond();
    endtask : wr
    task automatic rd(input logic [7:0] exp);
        logic [7:0] r;
        logic       a;
        i_tpsc_host_model.start_cond();
        i_tpsc_host_model.xfer(ADRW | 8'h01, 1'b1, r, a);
        chk("read ack", 16'h1, 16'(a));
        // master ack on the first byte, release on the second
        for (int k = 0; k < 2; k++) begin
            i_tpsc_host_model.xfer(8'hFF, 1'(k), r, a);
            chk("status", 16'(exp), 16'(r));
        end
        i_tpsc_host_model.stop_cond();
    endtask : rd
    ////////////////////////////////////////////////////////////////////////////////
    initial begin
        clk = 1'b0;
        forever #4 clk = ~clk;
    end
    always @(posedge clk) begin
        // one-cycle tick pulses, every 16 and every 32 clocks
        tick    <= rst_b ? tick + 8'h01 : 8'h00;
        refTick <= rst_b & (&tick[3:0]);
        divTick <= rst_b & (&tick[4:0]);
    end
    initial begin
        repeat (60000) @(posedge clk);
        err_count++;
        finish_test();
    end
    initial begin
        {rst_b, agcActiveIn} = '0;
        lockFlagIn = 1'b1;
        addressSelectInput = 2'h2;
        converterCodeIn = 3'h5;
        repeat (20) @(posedge clk);
        chk("reset band", 16'h09, 16'(band));
        chk("reset ctrl", 16'h32, 16'(ctl));
        rst_b <= 1'b1;
        repeat (8) @(posedge clk);
        chk("ports", 16'h0, 16'(ports));
        chk("band", 16'h09, 16'(band));
        chk("ctrl", 16'h32, 16'(ctl));
        chk("ratio", 16'h50, 16'(refDivRatio));
        chk("takeover", 16'h70, 16'(takeoverDbuv));
        endt("defaults");
        rd(8'hF5);
        {lockFlagIn, agcActiveIn, converterCodeIn} <= 5'b01010;
        rd(8'h3A);
        endt("status");
        wr('{ADRW, 8'h2A, 8'h5C, 8'h86, 8'h5D, 8'hDB, 8'hE0}, 1'b1);
        chk("divider", 16'h2A5C, 16'(dividerRatioBits));
        chk("ports", 16'h2F, 16'(ports));
        chk("band", 16'h14, 16'(band));
        chk("ctrl", 16'h37, 16'(ctl));
        chk("ratio", 16'h80, 16'(refDivRatio));
        chk("agc", 16'h300, 16'(agc));
        endt("full write");
        rat = 8'h80;
        bnd = 2'b00;
        for (int i = 0; i < 8; i++) begin
            wr('{ADRW, {2'b11, 3'(i), rsTab[i % 4], 1'b0}, {6'h0, 2'(i)}}, 1'b1);
            if (i % 4 != 3) rat = ratTab[i % 4];
            if (i != 3) bnd = 2'(i);
            chk("ratio", 16'(rat), 16'(refDivRatio));
            chk("mode", 16'({3'(i), i == 2, i == 6, i == 7}), 16'(pump));
            chk("band", 16'({bnd[0], bnd[1] | ~bnd[0], bnd[0], bnd[1], ~|bnd}), 16'(band));
            chk("band ports", 16'({bnd[0], bnd[1]}), 16'(ports[5:4]));
            chg = 0;
            last = sharedPinOe;
            repeat (100) begin
                @(posedge clk);
                if (sharedPinOe !== last) chg++;
                last = sharedPinOe;
            end
            chk("wave", 16'(i == 4 || i == 5), 16'(chg != 0));
        end
        endt("modes");
        for (int j = 0; j < 8; j++) begin
            wr('{ADRW, 8'hD9, {1'(j), 3'(j), 4'h0}}, 1'b1);
            chk("takeover", 16'({1'(j), j == 6, j == 7, topTab[j]}), 16'(agc));
        end
        endt("agc");
        wr('{ADRW, 8'h11}, 1'b1);
        chk("divider", 16'h2A5C, 16'(dividerRatioBits));
        wr('{{5'h18, 2'b01, 1'b0}, 8'h86}, 1'b0);
        chk("test", 16'h3, 16'(testField));
        endt("partial and foreign");
        finish_test();
    end
endmodule : tb_tpsc_serial_ctrl
